// >>> src/gpt_unit.sv
// general purpose timer unit: two timer modules, five 16-bit timers
//
// Notes on behaviour
// - five 16-bit timers, three plus two
// - concatenation only within own module
// - first module: timer, gated, counter, incremental modes
// - timer uses prescaled clock; counter uses pin
// - gated mode counts only while gate enables
// - first module resolution one step per 16
// - direction by software, altered by direction pin
// - incremental mode derives count from quadrature
// - core latch toggles on wrap; output, clocks aux
// - aux stopped while capture or reload register
// - aux captures core on its input pin
// - core reloads from aux on pin or latch
// - both aux alternate reloads for PWM
// - second module resolution one step per 8
// - second timers: prescaled clock or external signal
// - second core latch toggles; clocks aux, output
// - second core wrap pulses out, reloads from capture
// - capture pin copies second aux, optional clear
// - capture also from core input/direction transitions
module gpt_unit
(
	input  logic                  clk,
	input  logic                  reset,
	input  logic [2:0]            g1_in_pin,
	input  logic [2:0]            g1_dir_pin,
	input  logic [1:0]            g2_in_pin,
	input  logic [1:0]            g2_dir_pin,
	input  logic                  capture_input_pin,
	input  logic [2:0][1:0]       g1_mode,
	input  logic [2:0][2:0]       g1_presc,
	input  logic [2:0]            g1_run,
	input  logic [2:0]            g1_sw_down,
	input  logic [2:0]            g1_ext_dir_en,
	input  logic [2:0]            g1_gate_high,
	input  logic [2:0][1:0]       g1_edge,
	input  logic [1:0][1:0]       aux_func,
	input  logic [1:0]            aux_concat,
	input  logic [1:0][1:0]       aux_reload_edge,
	input  logic                  core_out_en,
	input  logic [1:0][2:0]       g2_presc,
	input  logic [1:0]            g2_run,
	input  logic [1:0]            g2_ext_clk,
	input  logic [1:0][1:0]       g2_edge,
	input  logic [1:0]            g2_sw_down,
	input  logic [1:0]            g2_ext_dir_en,
	input  logic                  saux_concat,
	input  logic                  score_reload_en,
	input  logic                  score_out_en,
	input  logic [2:0]            cap_src,
	input  logic [1:0]            cap_edge,
	input  logic                  saux_clear_en,
	input  logic [4:0]            wr_en,
	input  gpt_pkg::gpt_word_t    wr_data,
	input  logic                  cap_reg_wr,
	output gpt_pkg::gpt_word_t    aux_timer_lo,
	output gpt_pkg::gpt_word_t    core_timer,
	output gpt_pkg::gpt_word_t    aux_timer_hi,
	output gpt_pkg::gpt_word_t    second_aux_timer,
	output gpt_pkg::gpt_word_t    second_core_timer,
	output gpt_pkg::gpt_word_t    capture_reload_register,
	output logic                  core_toggle_output,
	output logic                  second_core_toggle_output,
	output logic                  score_wrap_pulse
);
	import gpt_pkg::*;

	typedef struct packed {
		logic [N_PINS-1:0] s1;
		logic [N_PINS-1:0] s2;
		logic [N_PINS-1:0] s3;
		gpt_word_t         presc;
		logic              core_latch;
		logic              score_latch;
		logic              core_out;
		logic              score_out;
		logic              score_pulse;
		gpt_word_t         cap_reg;
	} gpt_unit_state_t;

	gpt_unit_state_t st;
	gpt_unit_state_t next_st;

	logic [N_PINS-1:0] rise;
	logic [N_PINS-1:0] fall;
	logic [2:0]        g1_en;
	logic [2:0]        g1_up;
	logic [2:0]        g1_ld;
	logic [2:0]        g1_wrap;
	logic [2:0][15:0]  g1_ldv;
	logic [2:0][15:0]  g1_val;
	logic [1:0]        g2_en;
	logic [1:0]        g2_up;
	logic [1:0]        g2_ld;
	logic [1:0]        g2_wrap;
	logic [1:0][15:0]  g2_ldv;
	logic [1:0][15:0]  g2_val;
	logic [1:0]        cap_aux;
	logic [1:0]        rel_aux;
	logic              core_rise;
	logic              core_fall;
	logic              score_rise;
	logic              score_fall;
	logic              cap_evt;

	// one-cycle tick every (2^(base+ps)) clocks from the free prescaler
	function automatic logic prescale_tick(input gpt_word_t cnt, input logic [2:0] base, input logic [2:0] ps);
		gpt_word_t mask;
		// sum widened by one bit so base 3 plus ps 7 cannot wrap
		mask = (PRESC_ONE << ({1'b0, base} + {1'b0, ps})) - PRESC_ONE;
		return (cnt & mask) == mask;
	endfunction

	function automatic logic edge_hit(input logic r, input logic f, input logic [1:0] sel);
		return (r & sel[0]) | (f & sel[1]);
	endfunction

	// edges only from the second sync stage and its delayed copy
	assign rise = st.s2 & ~st.s3;
	assign fall = ~st.s2 & st.s3;

	// toggle latch transitions happen on the wrap pulse itself
	assign core_rise  = g1_wrap[CORE] & ~st.core_latch;
	assign core_fall  = g1_wrap[CORE] & st.core_latch;
	assign score_rise = g2_wrap[SCORE] & ~st.score_latch;
	assign score_fall = g2_wrap[SCORE] & st.score_latch;

	always_comb begin
		logic tick;
		logic lvl;
		logic dlv;
		logic a_ch;
		logic b_ch;
		logic in_ev;
		logic en;
		logic down;
		tick  = 1'b0;
		lvl   = 1'b0;
		dlv   = 1'b0;
		a_ch  = 1'b0;
		b_ch  = 1'b0;
		in_ev = 1'b0;
		en    = 1'b0;
		down  = 1'b0;
		cap_aux = 2'h0;
		rel_aux = 2'h0;
		next_st = st;

		// two-stage synchronisers plus an edge-detect stage
		next_st.s1    = {capture_input_pin, g2_dir_pin, g2_in_pin, g1_dir_pin, g1_in_pin};
		next_st.s2    = st.s1;
		next_st.s3    = st.s2;
		next_st.presc = st.presc + PRESC_ONE;

		// first module: mode select per timer
		for (int i = 0; i < 3; i++) begin
			tick  = prescale_tick(st.presc, G1_BASE_LOG, g1_presc[i]);
			lvl   = st.s2[PIN_G1_IN + i];
			dlv   = st.s2[PIN_G1_DIR + i];
			a_ch  = rise[PIN_G1_IN + i] | fall[PIN_G1_IN + i];
			b_ch  = rise[PIN_G1_DIR + i] | fall[PIN_G1_DIR + i];
			in_ev = edge_hit(rise[PIN_G1_IN + i], fall[PIN_G1_IN + i], g1_edge[i]);
			down  = g1_sw_down[i] ^ (g1_ext_dir_en[i] & dlv);
			if (i != CORE && aux_concat[i / 2] && g1_mode[i] == MODE_COUNTER) begin
				en = edge_hit(core_rise, core_fall, g1_edge[i]);
			end else begin
				case (g1_mode[i])
					MODE_TIMER: begin
						en = tick;
					end
					MODE_GATED: begin
						en = tick & (lvl == g1_gate_high[i]);
					end
					MODE_COUNTER: begin
						en = in_ev;
					end
					default: begin
						// both channels moving at once is invalid and ignored
						en   = a_ch ^ b_ch;
						down = g1_sw_down[i] ^ (a_ch ? (lvl == dlv) : (lvl != dlv));
					end
				endcase
			end
			if (i != CORE) begin
				if (aux_func[i / 2] != FUNC_BASIC) begin
					en = 1'b0;
				end
				cap_aux[i / 2] = aux_func[i / 2] == FUNC_CAPTURE && in_ev;
				rel_aux[i / 2] = aux_func[i / 2] == FUNC_RELOAD && (in_ev
					| edge_hit(core_rise, core_fall, aux_reload_edge[i / 2]));
			end
			g1_en[i] = g1_run[i] & en;
			g1_up[i] = ~down;
		end

		// aux loads: software write beats capture of the core value
		g1_ld[AUX_LO]  = wr_en[AUX_LO] | cap_aux[0];
		g1_ldv[AUX_LO] = wr_en[AUX_LO] ? wr_data : g1_val[CORE];
		g1_ld[AUX_HI]  = wr_en[AUX_HI] | cap_aux[1];
		g1_ldv[AUX_HI] = wr_en[AUX_HI] ? wr_data : g1_val[CORE];

		// core reload: with opposite latch edges the two aux words alternate
		g1_ld[CORE] = wr_en[CORE] | rel_aux[0] | rel_aux[1];
		if (wr_en[CORE]) begin
			g1_ldv[CORE] = wr_data;
		end else if (rel_aux[0]) begin
			g1_ldv[CORE] = g1_val[AUX_LO];
		end else begin
			g1_ldv[CORE] = g1_val[AUX_HI];
		end

		// second module: prescaled or external clock
		for (int i = 0; i < 2; i++) begin
			tick  = prescale_tick(st.presc, G2_BASE_LOG, g2_presc[i]);
			in_ev = edge_hit(rise[PIN_G2_IN + i], fall[PIN_G2_IN + i], g2_edge[i]);
			if (i == SAUX && saux_concat) begin
				en = edge_hit(score_rise, score_fall, g2_edge[i]);
			end else begin
				en = g2_ext_clk[i] ? in_ev : tick;
			end
			g2_en[i] = g2_run[i] & en;
			g2_up[i] = ~(g2_sw_down[i] ^ (g2_ext_dir_en[i] & st.s2[PIN_G2_DIR + i]));
		end

		// capture into the capture/reload register
		cap_evt = (cap_src[CAP_PIN] & edge_hit(rise[PIN_CAP], fall[PIN_CAP], cap_edge))
			| (cap_src[CAP_CIN] & edge_hit(rise[PIN_G1_IN + CORE], fall[PIN_G1_IN + CORE], cap_edge))
			| (cap_src[CAP_CDIR] & edge_hit(rise[PIN_G1_DIR + CORE], fall[PIN_G1_DIR + CORE], cap_edge));
		g2_ld[SAUX]   = wr_en[3] | (cap_evt & saux_clear_en);
		g2_ldv[SAUX]  = wr_en[3] ? wr_data : TMR_RESET;
		g2_ld[SCORE]  = wr_en[4] | (g2_wrap[SCORE] & score_reload_en);
		g2_ldv[SCORE] = wr_en[4] ? wr_data : st.cap_reg;

		// hardware capture wins over a software write in the same cycle
		if (cap_evt) begin
			next_st.cap_reg = g2_val[SAUX];
		end else if (cap_reg_wr) begin
			next_st.cap_reg = wr_data;
		end

		// toggle latches and registered outputs
		next_st.core_latch  = st.core_latch ^ g1_wrap[CORE];
		next_st.score_latch = st.score_latch ^ g2_wrap[SCORE];
		next_st.core_out    = core_out_en & st.core_latch;
		next_st.score_out   = score_out_en & st.score_latch;
		next_st.score_pulse = g2_wrap[SCORE];
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// five timer slices, three in the first module and two in the second
	gpt_tmr_if g1_if[3] ();
	gpt_tmr_if g2_if[2] ();

	for (genvar i = 0; i < 3; i++) begin : g_g1
		assign g1_if[i].cnt_en   = g1_en[i];
		assign g1_if[i].up       = g1_up[i];
		assign g1_if[i].load     = g1_ld[i];
		assign g1_if[i].load_val = g1_ldv[i];
		assign g1_val[i]         = g1_if[i].value;
		assign g1_wrap[i]        = g1_if[i].wrap;
		gpt_timer u_tmr (
			.clk   (clk),
			.reset (reset),
			.t     (g1_if[i])
		);
	end

	for (genvar i = 0; i < 2; i++) begin : g_g2
		assign g2_if[i].cnt_en   = g2_en[i];
		assign g2_if[i].up       = g2_up[i];
		assign g2_if[i].load     = g2_ld[i];
		assign g2_if[i].load_val = g2_ldv[i];
		assign g2_val[i]         = g2_if[i].value;
		assign g2_wrap[i]        = g2_if[i].wrap;
		gpt_timer u_tmr (
			.clk   (clk),
			.reset (reset),
			.t     (g2_if[i])
		);
	end

	// outputs straight from flip-flops
	assign aux_timer_lo              = g1_val[AUX_LO];
	assign core_timer                = g1_val[CORE];
	assign aux_timer_hi              = g1_val[AUX_HI];
	assign second_aux_timer          = g2_val[SAUX];
	assign second_core_timer         = g2_val[SCORE];
	assign capture_reload_register   = st.cap_reg;
	assign core_toggle_output        = st.core_out;
	assign second_core_toggle_output = st.score_out;
	assign score_wrap_pulse          = st.score_pulse;

	property p_latch_toggle;
		@(posedge clk) disable iff (reset)
		g1_wrap[CORE] |=> st.core_latch != $past(st.core_latch)
			##1 core_toggle_output == ($past(st.core_latch) & $past(core_out_en));
	endproperty
	a_latch_toggle: assert property (p_latch_toggle) else $error("core latch did not follow wrap");

	property p_aux_stopped;
		@(posedge clk) disable iff (reset)
		aux_func[0] != FUNC_BASIC && !g1_ld[AUX_LO] |=> $stable(aux_timer_lo);
	endproperty
	a_aux_stopped: assert property (p_aux_stopped) else $error("aux timer counted while coupled");

	property p_capture_core;
		@(posedge clk) disable iff (reset)
		cap_aux[0] && !wr_en[AUX_LO] |=> aux_timer_lo == $past(core_timer);
	endproperty
	a_capture_core: assert property (p_capture_core) else $error("core value not captured");

	property p_pwm_reload;
		@(posedge clk) disable iff (reset)
		rel_aux[0] && !wr_en[CORE] |=> core_timer == $past(aux_timer_lo);
	endproperty
	a_pwm_reload: assert property (p_pwm_reload) else $error("core not reloaded from aux");

	property p_gate_closed;
		@(posedge clk) disable iff (reset)
		g1_mode[AUX_LO] == MODE_GATED && st.s2[PIN_G1_IN + AUX_LO] != g1_gate_high[AUX_LO] && !g1_ld[AUX_LO]
			|=> $stable(aux_timer_lo);
	endproperty
	a_gate_closed: assert property (p_gate_closed) else $error("gated timer counted with gate closed");

	property p_score_reload;
		@(posedge clk) disable iff (reset)
		g2_wrap[SCORE] && score_reload_en && !wr_en[4] |=> second_core_timer == $past(st.cap_reg) && score_wrap_pulse;
	endproperty
	a_score_reload: assert property (p_score_reload) else $error("second core reload or pulse missing");

	property p_cap_reg_capture;
		@(posedge clk) disable iff (reset)
		cap_evt |=> capture_reload_register == $past(second_aux_timer)
			&& (!$past(saux_clear_en) || $past(wr_en[3]) || second_aux_timer == TMR_RESET);
	endproperty
	a_cap_reg_capture: assert property (p_cap_reg_capture) else $error("capture or clear of second aux wrong");
endmodule

// >>> pkg/gpt_pkg.sv
// shared constants and types of the general purpose timer unit
package gpt_pkg;
	typedef logic [15:0] gpt_word_t;

	// resolution in clock time units; two time units per clock period
	localparam int CTU_PER_CLK = 2;
	localparam int G1_RES_CTU  = 16;
	localparam int G2_RES_CTU  = 8;
	localparam logic [2:0] G1_BASE_LOG = 3'($clog2(G1_RES_CTU / CTU_PER_CLK));
	localparam logic [2:0] G2_BASE_LOG = 3'($clog2(G2_RES_CTU / CTU_PER_CLK));

	localparam gpt_word_t TMR_RESET = 16'h0000;
	localparam gpt_word_t TMR_MIN   = 16'h0000;
	localparam gpt_word_t TMR_MAX   = 16'hffff;
	localparam gpt_word_t PRESC_ONE = 16'h0001;

	// first module timer modes
	localparam logic [1:0] MODE_TIMER   = 2'h0;
	localparam logic [1:0] MODE_GATED   = 2'h1;
	localparam logic [1:0] MODE_COUNTER = 2'h2;
	localparam logic [1:0] MODE_INCR    = 2'h3;

	// auxiliary timer functions
	localparam logic [1:0] FUNC_BASIC   = 2'h0;
	localparam logic [1:0] FUNC_RELOAD  = 2'h1;
	localparam logic [1:0] FUNC_CAPTURE = 2'h2;

	// edge selections
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;

	// timer indices
	localparam int AUX_LO = 0;
	localparam int CORE   = 1;
	localparam int AUX_HI = 2;
	localparam int SAUX   = 0;
	localparam int SCORE  = 1;

	// capture source bits
	localparam int CAP_PIN  = 0;
	localparam int CAP_CIN  = 1;
	localparam int CAP_CDIR = 2;

	// positions in the synchronised pin vector
	localparam int PIN_G1_IN  = 0;
	localparam int PIN_G1_DIR = 3;
	localparam int PIN_G2_IN  = 6;
	localparam int PIN_G2_DIR = 8;
	localparam int PIN_CAP    = 10;
	localparam int N_PINS     = 11;
endpackage

// >>> pkg/gpt_tmr_if.sv
// control and status of one 16-bit timer
interface gpt_tmr_if;
	import gpt_pkg::*;
	logic      cnt_en;
	logic      up;
	logic      load;
	gpt_word_t load_val;
	gpt_word_t value;
	logic      wrap;
	modport tmr (input cnt_en, input up, input load, input load_val, output value, output wrap);
	modport ctl (output cnt_en, output up, output load, output load_val, input value, input wrap);
endinterface

// >>> src/gpt_timer.sv
// one 16-bit up/down timer with load and wrap detection
module gpt_timer
(
	input  logic clk,
	input  logic reset,
	gpt_tmr_if.tmr t
);
	import gpt_pkg::*;
	typedef struct packed {
		gpt_word_t value;
	} gpt_tmr_state_t;

	gpt_tmr_state_t st;
	gpt_tmr_state_t next_st;

	// load beats counting so a reload on wrap replaces the wrapped value
	always_comb begin
		next_st = st;
		if (t.load) begin
			next_st.value = t.load_val;
		end else if (t.cnt_en) begin
			next_st.value = t.up ? st.value + PRESC_ONE : st.value - PRESC_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st.value <= TMR_RESET;
		end else begin
			st <= next_st;
		end
	end

	// wrap ignores load, so reload-on-wrap forms no loop
	assign t.value = st.value;
	assign t.wrap  = t.cnt_en & (t.up ? st.value == TMR_MAX : st.value == TMR_MIN);

	property p_wrap_up;
		@(posedge clk) disable iff (reset)
		t.cnt_en && t.up && !t.load && st.value == TMR_MAX |=> st.value == TMR_MIN && $past(t.wrap);
	endproperty
	a_wrap_up: assert property (p_wrap_up) else $error("overflow did not wrap to zero");

	property p_count_down;
		@(posedge clk) disable iff (reset)
		t.cnt_en && !t.up && !t.load |=> st.value == $past(st.value) - PRESC_ONE;
	endproperty
	a_count_down: assert property (p_count_down) else $error("down count wrong");

	property p_load;
		@(posedge clk) disable iff (reset)
		t.load |=> st.value == $past(t.load_val);
	endproperty
	a_load: assert property (p_load) else $error("load value not taken");
endmodule

// >>> sim/gpt_pin_src.sv
// pin-side sources: count pulses, gate levels and a quadrature sensor
module gpt_pin_src
(
	input  logic                       clk,
	output logic [gpt_pkg::N_PINS-1:0] pins
);
	timeunit 1ns;
	timeprecision 1ps;
	import gpt_pkg::*;

	initial pins = '0;

	// each level is held 4 clocks, longer than the 2-flop sync plus edge detect
	task automatic set_lvl(input int p, input logic lvl);
		@(negedge clk);
		pins[p] = lvl;
		repeat (4) @(negedge clk);
	endtask

	// one rising and one falling transition
	task automatic pulse(input int p);
		set_lvl(p, ~pins[p]);
		set_lvl(p, ~pins[p]);
	endtask

	// gray steps: only one of a and b changes per step, never both at once
	task automatic quad(input int a, input int b, input logic back, input int cnt);
		for (int i = 0; i < cnt; i++) begin
			if ((pins[a] ^ pins[b]) == back) set_lvl(a, ~pins[a]);
			else set_lvl(b, ~pins[b]);
		end
	endtask
endmodule

// >>> sim/test_gpt_unit.sv
// self-checking bench of the general purpose timer unit
`define CHK(a, e) chk(16'(a), 16'(e))
module test_gpt_unit;
	timeunit 1ns;
	timeprecision 1ps;
	import gpt_pkg::*;

	logic              clk = 1'b0;
	logic              reset = 1'b1;
	logic [N_PINS-1:0] pins;
	logic [2:0]        g1_in_pin, g1_dir_pin, g1_run, g1_sw_down, g1_ext_dir_en, g1_gate_high, cap_src;
	logic [1:0]        g2_in_pin, g2_dir_pin, aux_concat, g2_run, g2_ext_clk, g2_sw_down, g2_ext_dir_en, cap_edge;
	logic              capture_input_pin, core_out_en, saux_concat, score_reload_en, score_out_en;
	logic              saux_clear_en, cap_reg_wr, core_toggle_output, second_core_toggle_output, score_wrap_pulse;
	logic [2:0][1:0]   g1_mode, g1_edge;
	logic [2:0][2:0]   g1_presc;
	logic [1:0][1:0]   aux_func, aux_reload_edge, g2_edge;
	logic [1:0][2:0]   g2_presc;
	logic [4:0]        wr_en;
	gpt_word_t         wr_data, aux_timer_lo, core_timer, aux_timer_hi, second_aux_timer, second_core_timer;
	gpt_word_t         capture_reload_register, v;
	int                n_fail = 0;
	int                n_compared = 0;
	int                n, m;

	// one vector from the source model feeds every pin input
	assign {capture_input_pin, g2_dir_pin, g2_in_pin, g1_dir_pin, g1_in_pin} = pins;

	always #10 clk = ~clk;

	gpt_pin_src src (.clk(clk), .pins(pins));
	gpt_unit uut (.*);

	task automatic give_verdict();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input gpt_word_t got, input gpt_word_t exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic gpt_word_t rd(input int k);
		case (k)
			0: return aux_timer_lo;
			1: return core_timer;
			2: return aux_timer_hi;
			3: return second_aux_timer;
			4: return second_core_timer;
			default: return capture_reload_register;
		endcase
	endfunction

	// controls and pins cleared before the first wait; a stale high pin reads as an edge after reset
	task automatic do_reset();
		reset = 1'b1;
		src.pins = '0;
		{g1_mode, g1_presc, g1_run, g1_sw_down, g1_ext_dir_en, g1_gate_high, g1_edge, aux_func, aux_concat} = '0;
		{aux_reload_edge, core_out_en, g2_presc, g2_run, g2_ext_clk, g2_edge, g2_sw_down, g2_ext_dir_en} = '0;
		{saux_concat, score_reload_en, score_out_en, cap_src, cap_edge, saux_clear_en, wr_en, wr_data} = '0;
		cap_reg_wr = 1'b0;
		repeat (20) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
	endtask

	// index 5 writes the capture register, the others a timer
	task automatic wr(input int k, input gpt_word_t d);
		@(negedge clk);
		if (k == 5) cap_reg_wr = 1'b1;
		else wr_en[k] = 1'b1;
		wr_data = d;
		@(negedge clk);
		wr_en = '0;
		cap_reg_wr = 1'b0;
	endtask

	// bounded wait for a value change; cnt gives the clocks waited
	task automatic wait_chg(input int k, output int cnt);
		gpt_word_t v0;
		v0 = rd(k);
		cnt = 0;
		while (rd(k) === v0 && cnt < 400) begin
			@(negedge clk);
			cnt++;
		end
		if (cnt >= 400) begin
			n_fail++;
			$display("[ERR] %0t no change on timer %0d", $time, k);
			give_verdict();
		end
	endtask

	initial begin
		do_reset();
		for (int k = 0; k < 6; k++) `CHK(rd(k), TMR_RESET);
		// core timer: prescaled steps, wrap, latch, direction; aux_timer_hi counts latch transitions
		g1_mode[AUX_HI] = MODE_COUNTER;
		g1_edge[AUX_HI] = 2'h3;
		aux_concat[1] = 1'b1;
		g1_run[AUX_HI] = 1'b1;
		wr(CORE, 16'hfffe);
		core_out_en = 1'b1;
		g1_run[CORE] = 1'b1;
		wait_chg(CORE, n);
		`CHK(core_timer, 16'hffff);
		wait_chg(CORE, n);
		`CHK(core_timer, TMR_MIN);
		`CHK(n, G1_RES_CTU / CTU_PER_CLK);
		repeat (3) @(negedge clk);
		`CHK(core_toggle_output, 1'b1);
		g1_presc[CORE] = 3'h1;
		wait_chg(CORE, n);
		wait_chg(CORE, n);
		`CHK(n, (G1_RES_CTU / CTU_PER_CLK) << 1);
		g1_sw_down[CORE] = 1'b1;
		wr(CORE, TMR_MIN);
		wait_chg(CORE, n);
		`CHK(core_timer, TMR_MAX);
		`CHK(aux_timer_hi, 16'h0002);
		g1_ext_dir_en[CORE] = 1'b1;
		src.set_lvl(PIN_G1_DIR + CORE, 1'b1);
		v = core_timer;
		wait_chg(CORE, n);
		`CHK(core_timer, v + 16'h0001);
		// gated, counter and incremental modes; capture from core pin transitions
		do_reset();
		g1_mode = {MODE_COUNTER, MODE_INCR, MODE_GATED};
		g1_gate_high[AUX_LO] = 1'b1;
		g1_edge[AUX_HI] = EDGE_RISE;
		g1_run = 3'h7;
		repeat (40) @(negedge clk);
		`CHK(aux_timer_lo, TMR_MIN);
		src.set_lvl(PIN_G1_IN + AUX_LO, 1'b1);
		wait_chg(AUX_LO, n);
		`CHK(aux_timer_lo, 16'h0001);
		src.set_lvl(PIN_G1_IN + AUX_LO, 1'b0);
		v = aux_timer_lo;
		repeat (40) @(negedge clk);
		`CHK(aux_timer_lo, v);
		repeat (3) src.pulse(PIN_G1_IN + AUX_HI);
		`CHK(aux_timer_hi, 16'h0003);
		g1_edge[AUX_HI] = 2'h3;
		repeat (2) src.pulse(PIN_G1_IN + AUX_HI);
		`CHK(aux_timer_hi, 16'h0007);
		wr(3, 16'h1234);
		cap_src[CAP_CIN] = 1'b1;
		cap_src[CAP_CDIR] = 1'b1;
		cap_edge = 2'h3;
		src.quad(PIN_G1_IN + CORE, PIN_G1_DIR + CORE, 1'b0, 4);
		v = core_timer;
		`CHK(v == 16'h0004 || v == 16'hfffc, 1'b1);
		src.quad(PIN_G1_IN + CORE, PIN_G1_DIR + CORE, 1'b1, 6);
		`CHK(core_timer, (v == 16'h0004) ? 16'hfffe : 16'h0002);
		`CHK(capture_reload_register, 16'h1234);
		// aux as capture, then both aux reloading core alternately
		do_reset();
		wr(CORE, 16'h5a5a);
		aux_func[0] = FUNC_CAPTURE;
		g1_edge[AUX_LO] = EDGE_RISE;
		g1_run[AUX_LO] = 1'b1;
		repeat (40) @(negedge clk);
		`CHK(aux_timer_lo, TMR_MIN);
		src.pulse(PIN_G1_IN + AUX_LO);
		`CHK(aux_timer_lo, 16'h5a5a);
		aux_func = {FUNC_RELOAD, FUNC_RELOAD};
		aux_reload_edge = {EDGE_FALL, EDGE_RISE};
		g1_run = 3'h7;
		wr(AUX_LO, 16'hfffc);
		wr(AUX_HI, 16'hfffe);
		wr(CORE, TMR_MAX);
		wait_chg(CORE, n);
		`CHK(core_timer, 16'hfffc);
		repeat (4) wait_chg(CORE, n);
		`CHK(core_timer, 16'hfffe);
		repeat (2) wait_chg(CORE, n);
		`CHK(core_timer, 16'hfffc);
		`CHK(aux_timer_lo, 16'hfffc);
		// second module: resolution, wrap pulse, reload, latch concatenation
		do_reset();
		score_out_en = 1'b1;
		score_reload_en = 1'b1;
		saux_concat = 1'b1;
		g2_edge[SAUX] = 2'h3;
		wr(4, 16'hfffe);
		wr(5, 16'hfff0);
		g2_run = 2'h3;
		wait_chg(4, n);
		wait_chg(4, n);
		`CHK(second_core_timer, 16'hfff0);
		m = 0;
		repeat (6) begin
			if (score_wrap_pulse === 1'b1) m++;
			@(negedge clk);
		end
		`CHK(m, 1);
		`CHK(second_aux_timer, 16'h0001);
		`CHK(second_core_toggle_output, 1'b1);
		wait_chg(4, n);
		wait_chg(4, n);
		`CHK(n, G2_RES_CTU / CTU_PER_CLK);
		// external clock, capture pin with clear, register write, pin direction
		do_reset();
		g2_ext_clk[SAUX] = 1'b1;
		g2_edge[SAUX] = EDGE_RISE;
		g2_run[SAUX] = 1'b1;
		repeat (5) src.pulse(PIN_G2_IN + SAUX);
		`CHK(second_aux_timer, 16'h0005);
		cap_src[CAP_PIN] = 1'b1;
		cap_edge = EDGE_FALL;
		saux_clear_en = 1'b1;
		src.pulse(PIN_CAP);
		`CHK(capture_reload_register, 16'h0005);
		`CHK(second_aux_timer, TMR_MIN);
		wr(5, 16'h0f0f);
		`CHK(capture_reload_register, 16'h0f0f);
		g2_ext_dir_en[SAUX] = 1'b1;
		src.set_lvl(PIN_G2_DIR + SAUX, 1'b1);
		src.pulse(PIN_G2_IN + SAUX);
		`CHK(second_aux_timer, TMR_MAX);
		give_verdict();
	end
endmodule
